//--- serial_port_pkg.sv
// ****************************************************************
// Constants of the shared serial configuration port.
// ****************************************************************
package serial_port_pkg;
  localparam logic [6:0] slave_addr_reset = 7'h58;
  localparam logic [7:0] page_offset_one_byte = 8'hfc;
  localparam logic [15:0] page_offset_two_byte = 16'hfffc;
  localparam int page_bytes = 4;
  localparam logic [7:0] page_reset = 8'h80;
  localparam logic [15:0] user_space_base = 16'h8000;
  localparam int master_phase_cycles = 64;
  localparam int scl_half_cycles = 50;
  typedef enum logic {proto_i2c, proto_spi} proto_e;
  typedef enum logic [2:0] {st_idle, st_dev, st_dev_ack, st_off, st_off_ack, st_wr, st_wr_ack, st_rd} i2c_state_e;
  typedef enum logic [1:0] {ph_master, ph_slave} phase_e;
endpackage

//--- config_serial_slave_port.sv
module config_serial_slave_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic proto_is_spi,
  input wire logic spi_three_wire,
  input wire logic two_byte_offset_mode,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic select_or_addr_strap_low,
  input wire logic serial_in_or_addr_strap_high,
  output logic master_active,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] page
);
  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  logic [1:0] scl_s, sda_s, a0_s, a1_s;
  logic scl_d, sda_d;
  always_ff @(posedge clock) begin
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
    a0_s <= {a0_s[0], select_or_addr_strap_low};
    a1_s <= {a1_s[0], serial_in_or_addr_strap_high};
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
  end
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  wire [6:0] my_addr = {serial_port_pkg::slave_addr_reset[6:2], a1_s[1], a0_s[1]};

  // ****************************************************************
  // Reset-time master phase. Only the clock is driven here; the
  // configuration fetch sequencing lives elsewhere and the idle
  // data line is released so no false start is seen.
  // ****************************************************************
  serial_port_pkg::phase_e phase, next_phase;
  logic [6:0] mcnt, next_mcnt;
  logic [5:0] hcnt, next_hcnt;
  logic mscl, next_mscl;
  always_comb begin
    next_phase = phase;
    next_mcnt = mcnt;
    next_hcnt = hcnt;
    next_mscl = mscl;
    if (phase == serial_port_pkg::ph_master) begin
      if (proto_is_spi || mcnt == 7'(serial_port_pkg::master_phase_cycles)) begin
        next_phase = serial_port_pkg::ph_slave;
        next_mscl = 1'b1;
      end else if (hcnt == 6'(serial_port_pkg::scl_half_cycles - 1)) begin
        next_hcnt = '0;
        next_mscl = ~mscl;
        next_mcnt = mcnt + 7'h01;
      end else begin
        next_hcnt = hcnt + 6'h01;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= serial_port_pkg::ph_master;
      mcnt <= '0;
      hcnt <= '0;
      mscl <= 1'b1;
    end else begin
      phase <= next_phase;
      mcnt <= next_mcnt;
      hcnt <= next_hcnt;
      mscl <= next_mscl;
    end
  end
  wire in_master = phase == serial_port_pkg::ph_master && !proto_is_spi;
  assign master_active = in_master;
  assign scl_out = mscl;
  assign scl_oe_n = ~in_master;

  // ****************************************************************
  // Slave engine: I2C framing or SPI shift, shared address pointer.
  // SPI frame: R/W bit, 15 offset bits, then data bytes.
  // ****************************************************************
  serial_port_pkg::i2c_state_e st, next_st;
  logic [7:0] sh, next_sh;
  logic [3:0] bc, next_bc;
  logic [15:0] ptr, next_ptr;
  logic off_hi, next_off_hi;
  logic rd, next_rd;
  logic drive, next_drive;
  logic [7:0] next_page;
  logic [2:0] pg_idx, next_pg_idx;
  logic [7:0] wd, next_wd;
  logic wr, next_wr, rr, next_rr;
  wire slave = phase == serial_port_pkg::ph_slave;
  wire spi_cs_n = a0_s[1];
  wire spi_din = spi_three_wire ? sda_s[1] : a1_s[1];
  wire [7:0] shifted = {sh[6:0], proto_is_spi ? spi_din : sda_s[1]};
  wire page_hit = two_byte_offset_mode ? ptr == serial_port_pkg::page_offset_two_byte
                                       : ptr[7:0] == serial_port_pkg::page_offset_one_byte;
  always_comb begin
    next_st = st;
    next_sh = sh;
    next_bc = bc;
    next_ptr = ptr;
    next_off_hi = off_hi;
    next_rd = rd;
    next_drive = drive;
    next_page = page;
    next_pg_idx = pg_idx;
    next_wd = wd;
    next_wr = 1'b0;
    next_rr = 1'b0;
    if (!slave || (proto_is_spi && spi_cs_n)) begin
      next_st = serial_port_pkg::st_idle;
      next_drive = 1'b0;
      next_bc = '0;
    end else if (!proto_is_spi && stop_c) begin
      next_st = serial_port_pkg::st_idle;
      next_drive = 1'b0;
    end else if (!proto_is_spi && start_c) begin
      next_st = serial_port_pkg::st_dev;
      next_bc = '0;
      next_drive = 1'b0;
    end else if (scl_rise && st != serial_port_pkg::st_idle && st != serial_port_pkg::st_dev_ack
                 && st != serial_port_pkg::st_off_ack && st != serial_port_pkg::st_wr_ack
                 && !(st == serial_port_pkg::st_rd && bc == 4'h9)) begin
      next_sh = shifted;
      next_bc = bc + 4'h1;
    end else if (scl_rise && st == serial_port_pkg::st_rd && bc == 4'h9 && sda_s[1]) begin
      // A refused byte ends the read, so the line stays free for the stop.
      next_st = serial_port_pkg::st_idle;
      next_drive = 1'b0;
    end else if (scl_rise && proto_is_spi && st == serial_port_pkg::st_idle) begin
      next_rd = spi_din;
      next_st = serial_port_pkg::st_off;
      next_off_hi = 1'b1;
      next_bc = 4'h1;
      next_sh = '0;
    end else if (scl_fall) begin
      unique case (st)
        serial_port_pkg::st_dev: if (bc == 4'h8) begin
          next_bc = '0;
          if (sh[7:1] == my_addr) begin
            next_rd = sh[0];
            next_st = serial_port_pkg::st_dev_ack;
            next_drive = 1'b1;
            next_sh = 8'h00;
          end else begin
            next_st = serial_port_pkg::st_idle;
          end
        end
        serial_port_pkg::st_dev_ack: begin
          next_st = rd ? serial_port_pkg::st_rd : serial_port_pkg::st_off;
          next_off_hi = two_byte_offset_mode;
          next_sh = reg_rdata;
          next_drive = rd && !reg_rdata[7];
          next_rr = rd;
        end
        serial_port_pkg::st_off: if (bc == 4'h8) begin
          next_bc = '0;
          if (off_hi) begin
            next_ptr[15:8] = sh;
            next_off_hi = !proto_is_spi;
            next_st = proto_is_spi ? serial_port_pkg::st_off : serial_port_pkg::st_off_ack;
          end else begin
            next_ptr[7:0] = sh;
            if (!two_byte_offset_mode) begin
              next_ptr[15:8] = page;
            end
            next_pg_idx = '0;
            next_st = proto_is_spi ? (rd ? serial_port_pkg::st_rd : serial_port_pkg::st_wr)
                                   : serial_port_pkg::st_off_ack;
          end
          next_drive = !proto_is_spi;
        end
        serial_port_pkg::st_off_ack: begin
          next_st = off_hi ? serial_port_pkg::st_off : serial_port_pkg::st_wr;
          next_off_hi = 1'b0;
          next_drive = 1'b0;
        end
        serial_port_pkg::st_wr: if (bc == 4'h8) begin
          next_bc = '0;
          next_wd = sh;
          if (page_hit || pg_idx != 3'h0) begin
            if (pg_idx == 3'h1) begin
              next_page = sh | serial_port_pkg::user_space_base[15:8];
            end
            next_pg_idx = pg_idx + 3'h1;
          end
          next_wr = 1'b1;
          next_st = proto_is_spi ? serial_port_pkg::st_wr : serial_port_pkg::st_wr_ack;
          next_drive = !proto_is_spi;
        end
        serial_port_pkg::st_wr_ack: begin
          next_st = serial_port_pkg::st_wr;
          next_drive = 1'b0;
        end
        serial_port_pkg::st_rd: if (bc == 4'h8) begin
          next_ptr = ptr + 16'h0001;
          next_drive = proto_is_spi;
          if (proto_is_spi) begin
            next_bc = '0;
            next_rr = 1'b1;
            next_sh = reg_rdata;
          end else begin
            // The host's acknowledge slot gives the image time to follow the pointer.
            next_bc = 4'h9;
          end
        end else if (bc == 4'h9) begin
          next_bc = '0;
          next_rr = 1'b1;
          next_sh = reg_rdata;
          next_drive = !reg_rdata[7];
        end else begin
          next_drive = proto_is_spi ? 1'b1 : !sh[7];
        end
        default: next_st = serial_port_pkg::st_idle;
      endcase
    end
    if (wr) begin
      next_ptr = ptr + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= serial_port_pkg::st_idle;
      sh <= '0;
      bc <= '0;
      ptr <= '0;
      off_hi <= 1'b0;
      rd <= 1'b0;
      drive <= 1'b0;
      page <= serial_port_pkg::page_reset;
      pg_idx <= '0;
      wd <= '0;
      wr <= 1'b0;
      rr <= 1'b0;
    end else begin
      st <= next_st;
      sh <= next_sh;
      bc <= next_bc;
      ptr <= next_ptr;
      off_hi <= next_off_hi;
      rd <= next_rd;
      drive <= next_drive;
      page <= next_page;
      pg_idx <= next_pg_idx;
      wd <= next_wd;
      wr <= next_wr;
      rr <= next_rr;
    end
  end
  assign reg_addr = ptr;
  assign reg_wdata = wd;
  assign reg_write = wr;
  assign reg_read = rr;
  // I2C drives low only; SPI drives the shifted bit on the data pin.
  assign sda_out = proto_is_spi ? sh[7] : 1'b0;
  assign sda_oe_n = ~(slave && drive);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_spi_no_master: assert property (@(posedge clock) disable iff (rst)
    proto_is_spi |-> !master_active && scl_oe_n) else $error("master active in SPI mode");
  a_master_ends: assert property (@(posedge clock) disable iff (rst)
    phase == serial_port_pkg::ph_slave |=> phase == serial_port_pkg::ph_slave && !master_active)
    else $error("master phase returned");
  a_write_advance: assert property (@(posedge clock) disable iff (rst)
    reg_write |=> reg_addr == $past(reg_addr) + 16'h0001) else $error("pointer did not advance");
  a_master_clock: assert property (@(posedge clock) disable iff (rst)
    master_active |-> !scl_oe_n) else $error("master not driving clock");
  a_stop_release: assert property (@(posedge clock) disable iff (rst)
    !proto_is_spi && stop_c |=> sda_oe_n) else $error("data line held after stop");
  a_page_upper: assert property (@(posedge clock) disable iff (rst)
    page[7]) else $error("page left the user space");
endmodule // config_serial_slave_port

//--- i2c_host_model.sv
// ****************************************
// Host at the far side of the serial port.
// ****************************************
module i2c_host_model (
  output logic scl_drv,
  output logic sda_drv,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of a 125 ns bit; the line is released high, as the pull-up leaves it.
  localparam realtime q = 31.25;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task start;
    sda_drv = 1'b1;
    #q scl_drv = 1'b1;
    #q sda_drv = 1'b0;
    #q scl_drv = 1'b0;
    #q;
  endtask
  task stop;
    sda_drv = 1'b0;
    #q scl_drv = 1'b1;
    #q sda_drv = 1'b1;
    #q;
  endtask
  task bit_io(input logic b, output logic r);
    sda_drv = b;
    #q scl_drv = 1'b1;
    #q r = sda_line;
    #q scl_drv = 1'b0;
    #q;
  endtask
  // One byte, most significant bit first, then the acknowledge slot; ack is set when the line is pulled low.
  task send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // i2c_host_model

//--- test_config_serial_slave_port.sv
// ****************************************
// Self-checking bench of the serial port.
// ****************************************
module test_config_serial_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, spi = 0, two_b = 0, seen_drive = 0;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, master_active, reg_write, reg_read, scl_drv, sda_drv;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata = 8'h00, page, pg, d0, d1, r0, r1;
  wire scl_line = scl_drv & (scl_oe_n | scl_out);
  wire sda_line = sda_drv & (sda_oe_n | sda_out);
  int fail_count = 0, num_checks = 0, cycles = 0, n_rd = 0;
  logic [23:0] wq[$];
  localparam logic [7:0] dev = {serial_port_pkg::slave_addr_reset[6:2], 2'b11, 1'b0};
  config_serial_slave_port u_dut (.clock(clock), .rst(rst), .proto_is_spi(spi), .spi_three_wire(1'b0),
    .two_byte_offset_mode(two_b), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_or_addr_strap_low(1'b1),
    .serial_in_or_addr_strap_high(1'b1), .master_active(master_active), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .page(page));
  i2c_host_model u_host (.scl_drv(scl_drv), .sda_drv(sda_drv), .sda_line(sda_line));
  function logic [7:0] img(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] b, input logic ea);
    logic a;
    u_host.send(b, a);
    chk(a, ea);
  endtask
  task do_reset(input logic s);
    @(negedge clock) rst = 1;
    spi = s;
    repeat (4) @(negedge clock);
    rst = 0;
  endtask
  initial forever #5 clock = ~clock;
  // The register image answers from the pointer, half a cycle behind it, on the falling edge.
  always @(negedge clock) reg_rdata <= img(reg_addr);
  always @(posedge clock) begin
    cycles++;
    if (reg_write) wq.push_back({reg_addr, reg_wdata});
    if (reg_read) n_rd++;
    if (!scl_oe_n && !scl_out) seen_drive = 1;
    if (cycles == 60000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h376e));
    do_reset(0);
    repeat (2) @(negedge clock);
    chk(master_active, 1);
    for (int i = 0; i < 5000 && master_active !== 1'b0; i++) @(negedge clock);
    chk(master_active, 0);
    chk(seen_drive, 1);
    pg = $urandom;
    d0 = $urandom;
    d1 = $urandom;
    u_host.start();
    wr(dev, 1); wr(8'hfc, 1); wr(8'h00, 1); wr(pg, 1); wr(8'h10, 1); wr(8'h20, 1);
    u_host.stop();
    repeat (20) @(negedge clock);
    chk(page, {1'b1, pg[6:0]});
    wq.delete();
    u_host.start();
    wr(dev, 1); wr(8'he4, 1); wr(d0, 1); wr(d1, 1);
    u_host.stop();
    repeat (20) @(negedge clock);
    chk(wq.size(), 2);
    chk(wq[0], {page, 8'he4, d0});
    chk(wq[1], {page, 8'he5, d1});
    n_rd = 0;
    u_host.start();
    wr(dev, 1); wr(8'h24, 1);
    u_host.start();
    wr(dev | 8'h01, 1);
    u_host.recv(1'b0, r0);
    u_host.recv(1'b1, r1);
    u_host.stop();
    chk(r0, img({page, 8'h24}));
    chk(r1, img({page, 8'h25}));
    chk(n_rd, 2);
    wq.delete();
    u_host.start();
    wr(dev ^ 8'h02, 0);
    u_host.stop();
    repeat (20) @(negedge clock);
    chk(wq.size(), 0);
    @(negedge clock) two_b = 1;
    u_host.start();
    wr(dev, 1); wr(8'hc0, 1); wr(8'h10, 1); wr(d1, 1);
    u_host.stop();
    repeat (20) @(negedge clock);
    chk(wq.size(), 1);
    chk(wq[0], {16'hc010, d1});
    do_reset(1);
    repeat (100) @(negedge clock);
    chk({master_active, scl_oe_n}, 2'b01);
    give_verdict();
  end
endmodule // test_config_serial_slave_port
